/* File: hub_ep_pkg.sv */
package hub_ep_pkg;

  // Change bitmap layout.
  localparam int          BITMAP_W      = 8;
  localparam int          HUB_BIT       = 0;
  localparam int          PORT_LSB      = 1;
  localparam int          NUM_PORTS     = 4;
  localparam logic [7:0]  BITMAP_RESET  = 8'h00;
  localparam logic [2:0]  RESERVED_VAL  = 3'h0;

  // Endpoint numbers.
  localparam logic [3:0]  EP_CONTROL    = 4'h0;
  localparam logic [3:0]  EP_INTERRUPT  = 4'h1;

  // Clocking: 200 MHz system clock, 12 MHz frame timer tick.
  localparam int          SYS_CLK_KHZ   = 200000;
  localparam int          BIT_CLK_KHZ   = 12000;
  localparam int          REF_CLK_KHZ   = 6000;
  localparam int          FRAME_BITS    = 12000;
  localparam int          FRAME_END_SAMPLE_MARKER_BITS     = 10;
  localparam int          SAMPLE_BIT    = FRAME_BITS - FRAME_END_SAMPLE_MARKER_BITS;

  // Standard and hub-class request codes.
  localparam logic [7:0]  REQ_GET_STATUS    = 8'h00;
  localparam logic [7:0]  REQ_CLEAR_FEATURE = 8'h01;
  localparam logic [7:0]  REQ_SET_FEATURE   = 8'h03;
  localparam logic [7:0]  REQ_SET_ADDRESS   = 8'h05;
  localparam logic [7:0]  REQ_GET_DESC      = 8'h06;
  localparam logic [7:0]  REQ_GET_CONFIG    = 8'h08;
  localparam logic [7:0]  REQ_SET_CONFIG    = 8'h09;

  // Request type values.
  localparam logic [7:0]  RT_DEVICE_OUT = 8'h00;
  localparam logic [7:0]  RT_HUB_OUT    = 8'h20;
  localparam logic [7:0]  RT_PORT_OUT   = 8'h23;

  // Descriptor type codes.
  localparam logic [7:0]  DT_DEVICE     = 8'h01;
  localparam logic [7:0]  DT_CONFIG     = 8'h02;
  localparam logic [7:0]  DT_INTERFACE  = 8'h04;
  localparam logic [7:0]  DT_ENDPOINT   = 8'h05;
  localparam logic [7:0]  DT_HUB        = 8'h29;

  // Token from the serial engine.
  typedef enum logic [1:0] {
    TOK_NONE  = 2'b00,
    TOK_SOF   = 2'b01,
    TOK_IN    = 2'b10,
    TOK_SETUP = 2'b11
  } token_t;

  // Handshake or payload choice for an IN poll.
  typedef enum logic [1:0] {
    ANS_NONE  = 2'b00,
    ANS_NAK   = 2'b01,
    ANS_DATA  = 2'b10,
    ANS_STALL = 2'b11
  } answer_t;

  // Decoded token as handed over by the serial engine.
  typedef struct packed {
    token_t     kind;
    logic [3:0] endp;
  } token_in_t;

  // Decoded setup packet, held in six bytes.
  typedef struct packed {
    logic [7:0]  reqType;
    logic [7:0]  request;
    logic [15:0] value;
    logic [15:0] index;
  } setup_t;

  // Answer toward the serial engine.
  typedef struct packed {
    answer_t    kind;
    logic [7:0] data;
  } answer_out_t;

endpackage

/* File: hub_endpoint_status_change.sv */
// Functional notes
// [R1] Endpoint 0 is the default control endpoint.
// [R2] Control endpoint answers standard, hub requests, descriptors.
// [R3] Configuration describes only the interrupt endpoint.
// [R4] Endpoint 1 is interrupt, change reports only.
// [R5] Capture change bitmap at each frame end marker.
// [R6] Bit 0 hub, bits 1-4 ports, rest zero.
// [R7] Zero bitmap on poll answers NAK.
// [R8] Nonzero bitmap sends the whole byte.
// [R9] Change persists until host clears it.
// [R10] No reports before host sets configuration.
// [R11] Clocks derive from a 6 MHz reference.
// [R12] Reference oscillator stops in suspend, restarts on resume.
// [R13] Frame timer at 12 MHz restarts on SOF.
// [R14] Configured flag set by Set_Configuration gates reporting.
// [R15] Bitmap bits OR the individual change flags.
`timescale 1ns/1ps
`default_nettype none

module hub_endpoint_status_change #(
  parameter int FLAGS_PER_PORT = 5,                  // Change flags per downstream port.
  parameter int HUB_FLAGS      = 2,                  // Hub-level change flags.
  parameter int FRAME_TICKS    = hub_ep_pkg::FRAME_BITS // Bit times per frame; a smaller value shortens simulation.
) (
  input  wire logic                        clk_sys,          // 200 MHz clock, derived from the 6 MHz reference.
  input  wire logic                        resetn,           // Asynchronous reset, active low.
  input  wire hub_ep_pkg::token_in_t       tokenIn,          // Decoded token, valid for one cycle.
  input  wire logic                        setupValid,       // One-cycle pulse with a decoded setup packet.
  input  wire hub_ep_pkg::setup_t          setupPkt,         // Setup packet fields.
  input  wire logic [hub_ep_pkg::NUM_PORTS*FLAGS_PER_PORT-1:0] portChange, // Per-port change flags, level.
  input  wire logic [HUB_FLAGS-1:0]        hubChange,        // Hub-level change flags, level.
  input  wire logic                        suspendReq,       // Bus idle long enough to suspend, level.
  input  wire logic                        resumeReq,        // Resume signalling seen, level.
  output logic                             answerValid,      // One-cycle pulse with an answer.
  output hub_ep_pkg::answer_out_t          answerOut,        // NAK, data byte or stall.
  output logic [7:0]                       descType,         // Descriptor type being returned.
  output logic                             descValid,        // One-cycle pulse starting a descriptor read.
  output logic                             clearPulse,       // One-cycle pulse: host cleared a feature.
  output logic [7:0]                       clearSelector,    // Feature selector of that clear.
  output logic [7:0]                       clearPort,        // Port number of that clear, 0 for the hub.
  output logic                             configured,       // Configured-state flag.
  output logic                             oscEnable,        // Reference oscillator enable.
  output logic [7:0]                       port_change_bitmap, // Sampled change bitmap.
  output logic                             frameEndSampleMarker // One-cycle pulse at the sampling point.
);

  // Derived counts; a 12 MHz tick is generated by a phase accumulator.
  // The accumulator must hold the modulus plus one step, which takes twenty bits at these rates.
  localparam int ACC_W = 20;
  localparam logic [ACC_W-1:0] TICK_STEP = ACC_W'((hub_ep_pkg::BIT_CLK_KHZ * 4096) / 1000); // see [R13]
  localparam logic [ACC_W-1:0] TICK_MOD  = ACC_W'((hub_ep_pkg::SYS_CLK_KHZ * 4096) / 1000);
  // The counter saturates at the frame end, so a missed start-of-frame gives no second marker.
  localparam logic [13:0]      SAMPLE_AT = 14'(FRAME_TICKS - hub_ep_pkg::FRAME_END_SAMPLE_MARKER_BITS);
  localparam logic [13:0]      FRAME_MAX = 14'(FRAME_TICKS - 1);

  typedef enum logic [1:0] {
    PWR_RUN     = 2'b00,
    PWR_SUSPEND = 2'b01,
    PWR_WAKE    = 2'b10
  } pwr_t;

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [13:0]      frameCnt;
    logic             marker;
    logic [7:0]       bitmap;
    logic             cfg;
    pwr_t             pwr;
    logic             osc;
    logic             ansValid;
    hub_ep_pkg::answer_out_t ans;
    logic [7:0]       dType;
    logic             dValid;
    logic             clr;
    logic [7:0]       clrSel;
    logic [7:0]       clrPort;
  } state_t;

  state_t st;
  state_t next_st;

  // Per-port OR of individual flags.
  logic [hub_ep_pkg::NUM_PORTS-1:0] portAny;
  genvar gp;
  generate
    for (gp = 0; gp < hub_ep_pkg::NUM_PORTS; gp++) begin : g_port
      assign portAny[gp] = |portChange[gp*FLAGS_PER_PORT +: FLAGS_PER_PORT]; // see [R15]
    end
  endgenerate

  // Reserved bits come from the package constant, never from an input.
  logic [7:0] sampled;
  assign sampled = {hub_ep_pkg::RESERVED_VAL, portAny, |hubChange}; // see [R6] see [R15]

  // Main next-state logic: frame timer, sampling, endpoint answers, requests.
  always_comb begin
    next_st          = st;
    next_st.marker   = 1'b0;
    next_st.ansValid = 1'b0;
    next_st.dValid   = 1'b0;
    next_st.clr      = 1'b0;
    // The timer only advances on a 12 MHz tick; the running oscillator is the only clock source.
    if (st.acc + TICK_STEP >= TICK_MOD) begin
      next_st.acc = st.acc + TICK_STEP - TICK_MOD;
      if (st.frameCnt != FRAME_MAX) begin
        next_st.frameCnt = st.frameCnt + 14'h0001;
      end
      if (st.frameCnt == SAMPLE_AT - 14'h0001) begin
        next_st.marker = 1'b1; // see [R5]
      end
    end else begin
      next_st.acc = st.acc + TICK_STEP;
    end
    // Restarting the phase as well keeps the marker a fixed number of bit times from the frame start.
    if (tokenIn.kind == hub_ep_pkg::TOK_SOF) begin
      next_st.frameCnt = 14'h0000; // see [R13]
      next_st.acc      = '0;
    end
    // Sources stay set until the host clears them, so resampling keeps reporting.
    if (st.marker) begin
      next_st.bitmap = st.cfg ? sampled : hub_ep_pkg::BITMAP_RESET; // see [R5] see [R9] see [R10]
    end
    // Clearing while unconfigured also drops a byte captured just before a deconfiguration.
    if (!st.cfg) begin
      next_st.bitmap = hub_ep_pkg::BITMAP_RESET; // see [R10]
    end
    // Interrupt endpoint poll.
    // The configured flag is tested too, so a stale byte never leaks in the cycle after deconfiguration.
    if (tokenIn.kind == hub_ep_pkg::TOK_IN && tokenIn.endp == hub_ep_pkg::EP_INTERRUPT) begin
      next_st.ansValid  = 1'b1; // see [R4]
      if (st.bitmap[4:0] != 5'h00 && st.cfg) begin
        next_st.ans.kind = hub_ep_pkg::ANS_DATA; // see [R8]
        next_st.ans.data = st.bitmap;
      end else begin
        next_st.ans.kind = hub_ep_pkg::ANS_NAK; // see [R7]
        next_st.ans.data = 8'h00;
      end
    end
    // Control endpoint requests.
    // A setup is only taken with endpoint 0 in the token, so it cannot override an interrupt poll's answer.
    if (setupValid && tokenIn.endp == hub_ep_pkg::EP_CONTROL) begin // see [R1]
      next_st.ansValid = 1'b1;
      next_st.ans.kind = hub_ep_pkg::ANS_DATA;
      next_st.ans.data = 8'h00;
      case (setupPkt.request)
        hub_ep_pkg::REQ_SET_CONFIG: begin
          next_st.cfg = setupPkt.value[0]; // see [R14]
        end
        hub_ep_pkg::REQ_GET_CONFIG: begin
          // The configured flag is reported in bit 0.
          next_st.ans.data = {7'h00, st.cfg};
        end
        hub_ep_pkg::REQ_GET_DESC: begin
          // Endpoint descriptors name only endpoint 1.
          next_st.dType  = setupPkt.value[15:8]; // see [R2] see [R3]
          next_st.dValid = 1'b1;
        end
        hub_ep_pkg::REQ_CLEAR_FEATURE: begin
          // The clear is only reported; the source outside drops its flag and the next capture follows.
          next_st.clr     = 1'b1; // see [R9]
          next_st.clrSel  = setupPkt.value[7:0];
          next_st.clrPort = (setupPkt.reqType == hub_ep_pkg::RT_PORT_OUT) ? setupPkt.index[7:0] : 8'h00;
        end
        hub_ep_pkg::REQ_GET_STATUS, hub_ep_pkg::REQ_SET_FEATURE, hub_ep_pkg::REQ_SET_ADDRESS: begin
          next_st.ans.kind = hub_ep_pkg::ANS_DATA; // see [R2]
        end
        default: begin
          next_st.ans.kind = hub_ep_pkg::ANS_STALL;
        end
      endcase
    end
    // Oscillator control across suspend and resume.
    // The wake state keeps the oscillator on until resume signalling ends, so it cannot drop straight back.
    case (st.pwr)
      PWR_RUN: begin
        if (suspendReq) begin
          next_st.pwr = PWR_SUSPEND; // see [R12]
        end
      end
      PWR_SUSPEND: begin
        if (resumeReq) begin
          next_st.pwr = PWR_WAKE; // see [R12]
        end
      end
      PWR_WAKE: begin
        if (!resumeReq) begin
          next_st.pwr = PWR_RUN;
        end
      end
      default: begin
        next_st.pwr = PWR_RUN;
      end
    endcase
    // Registered, so that the enable leaves a flip-flop in step with the power state.
    next_st.osc = (next_st.pwr != PWR_SUSPEND); // see [R11] see [R12]
  end

  // State register.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st     <= '0;
      // The oscillator runs out of reset; only a suspend stops it.
      st.osc <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from state flip-flops.
  assign answerValid          = st.ansValid;
  assign answerOut            = st.ans;
  assign descType             = st.dType;
  assign descValid            = st.dValid;
  assign clearPulse           = st.clr;
  assign clearSelector        = st.clrSel;
  assign clearPort            = st.clrPort;
  assign configured           = st.cfg;
  assign oscEnable            = st.osc; // see [R11] see [R12]
  assign port_change_bitmap   = st.bitmap;
  assign frameEndSampleMarker = st.marker;

endmodule

`default_nettype wire

/* File: hub_ep_status_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module hub_ep_status_chk #(
  parameter int FLAGS_PER_PORT = 5, // Flags per port.
  parameter int HUB_FLAGS      = 2  // Hub flags.
) (
  input wire logic                                          clk_sys,              // Clock.
  input wire logic                                          resetn,               // Reset.
  input wire hub_ep_pkg::token_in_t                         tokenIn,              // Token.
  input wire logic                                          setupValid,           // Setup strobe.
  input wire hub_ep_pkg::setup_t                            setupPkt,             // Setup fields.
  input wire logic [hub_ep_pkg::NUM_PORTS*FLAGS_PER_PORT-1:0] portChange,         // Port flags.
  input wire logic [HUB_FLAGS-1:0]                          hubChange,            // Hub flags.
  input wire logic                                          answerValid,          // Answer strobe.
  input wire hub_ep_pkg::answer_out_t                       answerOut,            // Answer.
  input wire logic [7:0]                                    descType,             // Descriptor type.
  input wire logic                                          descValid,            // Descriptor strobe.
  input wire logic                                          clearPulse,           // Clear strobe.
  input wire logic [7:0]                                    clearSelector,        // Clear selector.
  input wire logic [7:0]                                    clearPort,            // Clear port.
  input wire logic                                          configured,           // Configured flag.
  input wire logic [7:0]                                    port_change_bitmap,   // Bitmap.
  input wire logic                                          frameEndSampleMarker  // Marker.
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // A poll with a setup strobe in the same cycle is left out, so a poll only counts without one.
  wire logic poll = tokenIn.kind == hub_ep_pkg::TOK_IN && tokenIn.endp == hub_ep_pkg::EP_INTERRUPT && !setupValid;
  wire logic setup = setupValid && tokenIn.endp == hub_ep_pkg::EP_CONTROL;
  logic [7:0] expMap;
  // The bitmap that the flags call for, built independently of the design.
  always_comb begin
    expMap = {7'h00, |hubChange};
    for (int p = 0; p < hub_ep_pkg::NUM_PORTS; p++) begin
      expMap[p+1] = |portChange[p*FLAGS_PER_PORT +: FLAGS_PER_PORT];
    end
  end
  ans_latency_a: assert property (poll |=> answerValid) else $error("poll not answered");
  nak_empty_a: assert property (poll && port_change_bitmap == 8'h00
    |=> answerOut.kind == hub_ep_pkg::ANS_NAK) else $error("empty bitmap not refused");
  // Only while configured: in the cycle after deconfiguration the byte still stands but must be refused.
  data_whole_a: assert property (poll && configured && |port_change_bitmap[4:0]
    |=> answerOut.kind == hub_ep_pkg::ANS_DATA && answerOut.data == $past(port_change_bitmap))
    else $error("bitmap byte not sent");
  unconf_nak_a: assert property (poll && !configured |=> answerOut.kind == hub_ep_pkg::ANS_NAK)
    else $error("report before configuration");
  reserved_zero_a: assert property (port_change_bitmap[7:5] == hub_ep_pkg::RESERVED_VAL)
    else $error("reserved bits set");
  sample_map_a: assert property (frameEndSampleMarker && configured
    |=> port_change_bitmap == $past(expMap)) else $error("bitmap capture wrong");
  marker_pulse_a: assert property (frameEndSampleMarker |=> !frameEndSampleMarker)
    else $error("marker too long");
  hold_map_a: assert property (configured && $past(configured) && !$past(frameEndSampleMarker)
    |-> $stable(port_change_bitmap)) else $error("bitmap changed between markers");
  config_set_a: assert property (setup && setupPkt.request == hub_ep_pkg::REQ_SET_CONFIG
    && setupPkt.reqType == hub_ep_pkg::RT_DEVICE_OUT |=> configured == $past(setupPkt.value[0]))
    else $error("bad config");
  clear_info_a: assert property (setup && setupPkt.request == hub_ep_pkg::REQ_CLEAR_FEATURE
    && setupPkt.reqType == hub_ep_pkg::RT_PORT_OUT |=> clearPulse && clearPort == $past(setupPkt.index[7:0])
    && clearSelector == $past(setupPkt.value[7:0])) else $error("clear not reported");
  desc_type_a: assert property (setup && setupPkt.request == hub_ep_pkg::REQ_GET_DESC
    |=> descValid && descType == $past(setupPkt.value[15:8])) else $error("descriptor type wrong");
  cover property (poll ##1 answerOut.kind == hub_ep_pkg::ANS_DATA);
  cover property (frameEndSampleMarker && configured);
  cover property (setup ##1 answerOut.kind == hub_ep_pkg::ANS_STALL);
endmodule
bind hub_endpoint_status_change hub_ep_status_chk #(.FLAGS_PER_PORT(FLAGS_PER_PORT), .HUB_FLAGS(HUB_FLAGS))
  i_hub_ep_status_chk (.clk_sys(clk_sys), .resetn(resetn), .tokenIn(tokenIn), .setupValid(setupValid),
  .setupPkt(setupPkt), .portChange(portChange), .hubChange(hubChange), .answerValid(answerValid),
  .answerOut(answerOut), .descType(descType), .descValid(descValid), .clearPulse(clearPulse),
  .clearSelector(clearSelector), .clearPort(clearPort), .configured(configured),
  .port_change_bitmap(port_change_bitmap), .frameEndSampleMarker(frameEndSampleMarker));
`default_nettype wire

/* File: hub_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module hub_host_model (
  input  wire logic                clk_sys,    // Clock.
  output var hub_ep_pkg::token_in_t tokenIn,   // Token toward the hub.
  output var logic                 setupValid, // Setup strobe.
  output var hub_ep_pkg::setup_t   setupPkt    // Setup fields.
);
  // The bus starts idle.
  initial begin
    tokenIn = '0;
    setupValid = 1'b0;
    setupPkt = '0;
  end
  // A token stands for the one edge at which the hub takes it.
  task automatic send_token(input hub_ep_pkg::token_t kind, input logic [3:0] endp);
    @(posedge clk_sys);
    tokenIn <= '{kind, endp};
    @(posedge clk_sys);
    tokenIn <= '{hub_ep_pkg::TOK_NONE, 4'h0};
  endtask
  // The stale packet is inverted after release, so a late read cannot pass by luck.
  task automatic send_setup(input hub_ep_pkg::setup_t pkt);
    @(posedge clk_sys);
    tokenIn <= '{hub_ep_pkg::TOK_SETUP, hub_ep_pkg::EP_CONTROL};
    setupValid <= 1'b1;
    setupPkt <= pkt;
    @(posedge clk_sys);
    tokenIn <= '{hub_ep_pkg::TOK_NONE, 4'h0};
    setupValid <= 1'b0;
    setupPkt <= ~pkt;
  endtask
endmodule
`default_nettype wire

/* File: hub_endpoint_status_change_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module hub_endpoint_status_change_tb;
  logic                    clk_sys = 1'b0;
  logic                    resetn = 1'b0;
  logic [19:0]             portChange = 20'h00000;
  logic [1:0]              hubChange = 2'h0;
  logic                    suspendReq = 1'b0;
  logic                    resumeReq = 1'b0;
  hub_ep_pkg::token_in_t   tokenIn;
  logic                    setupValid;
  hub_ep_pkg::setup_t      setupPkt;
  hub_ep_pkg::answer_out_t answerOut;
  logic                    answerValid, descValid, clearPulse, configured, oscEnable, marker;
  logic [7:0]              descType, clearSelector, clearPort, bitmap;
  int                      n_errors = 0;
  int                      comparisons = 0;
  // Half of the 5 ns period.
  always #2.5 clk_sys = ~clk_sys;
  // A shortened frame keeps the run short; only the frame length differs from the device.
  hub_endpoint_status_change #(.FRAME_TICKS(1000)) i_hub_endpoint_status_change (
    .clk_sys(clk_sys), .resetn(resetn), .tokenIn(tokenIn),
    .setupValid(setupValid), .setupPkt(setupPkt), .portChange(portChange), .hubChange(hubChange),
    .suspendReq(suspendReq), .resumeReq(resumeReq), .answerValid(answerValid), .answerOut(answerOut),
    .descType(descType), .descValid(descValid), .clearPulse(clearPulse), .clearSelector(clearSelector),
    .clearPort(clearPort), .configured(configured), .oscEnable(oscEnable), .port_change_bitmap(bitmap),
    .frameEndSampleMarker(marker));
  hub_host_model i_hub_host_model (.clk_sys(clk_sys), .tokenIn(tokenIn), .setupValid(setupValid), .setupPkt(setupPkt));
  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Bounded wait on the marker or the oscillator enable; it looks 1 ns after each edge, where outputs are settled.
  task automatic wait_for(input logic onMarker, input logic val, input int lim);
    int n;
    n = 0;
    #1;
    while ((onMarker ? marker : oscEnable) !== val && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check((onMarker ? marker : oscEnable) === val, "wait ran out");
  endtask
  task automatic poll(input hub_ep_pkg::answer_t kind, input logic [7:0] data);
    i_hub_host_model.send_token(hub_ep_pkg::TOK_IN, hub_ep_pkg::EP_INTERRUPT);
    #1;
    check(answerValid === 1'b1 && answerOut.kind === kind, "poll answer");
    check(kind !== hub_ep_pkg::ANS_DATA || answerOut.data === data, "poll data");
  endtask
  task automatic req(input logic [7:0] rt, input logic [7:0] rq, input logic [15:0] v, input logic [15:0] ix);
    i_hub_host_model.send_setup('{rt, rq, v, ix});
    #1;
  endtask
  // Pending changes must still be refused before configuration.
  task automatic t_unconf();
    check(configured === 1'b0 && bitmap === 8'h00 && oscEnable === 1'b1, "reset values");
    @(posedge clk_sys);
    hubChange <= 2'h1;
    poll(hub_ep_pkg::ANS_NAK, 8'h00);
    check(bitmap === 8'h00, "bitmap before configuration");
    $display("test unconfigured done");
  endtask
  task automatic t_suspend();
    @(posedge clk_sys);
    suspendReq <= 1'b1;
    wait_for(1'b0, 1'b0, 1000);
    @(posedge clk_sys);
    suspendReq <= 1'b0;
    resumeReq <= 1'b1;
    wait_for(1'b0, 1'b1, 1000);
    @(posedge clk_sys);
    resumeReq <= 1'b0;
    $display("test suspend done");
  endtask
  task automatic t_control();
    logic [7:0] types [5] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h29};
    foreach (types[i]) begin
      req(8'h80, hub_ep_pkg::REQ_GET_DESC, {types[i], 8'h00}, 16'h0000);
      check(descValid === 1'b1 && descType === types[i], "descriptor type");
    end
    req(8'h80, 8'hFF, 16'h0000, 16'h0000);
    check(answerValid === 1'b1 && answerOut.kind === hub_ep_pkg::ANS_STALL, "unknown request");
    req(8'h80, hub_ep_pkg::REQ_GET_STATUS, 16'h0000, 16'h0000);
    check(answerValid === 1'b1 && answerOut.kind === hub_ep_pkg::ANS_DATA, "get status");
    req(hub_ep_pkg::RT_PORT_OUT, hub_ep_pkg::REQ_CLEAR_FEATURE, 16'h0010, 16'h0003);
    check(clearPulse === 1'b1 && clearPort === 8'h03 && clearSelector === 8'h10, "port clear");
    req(hub_ep_pkg::RT_HUB_OUT, hub_ep_pkg::REQ_CLEAR_FEATURE, 16'h0001, 16'h0003);
    check(clearPulse === 1'b1 && clearPort === 8'h00 && clearSelector === 8'h01, "hub clear");
    req(hub_ep_pkg::RT_DEVICE_OUT, hub_ep_pkg::REQ_SET_CONFIG, 16'h0001, 16'h0000);
    check(configured === 1'b1, "set configuration");
    req(8'h80, hub_ep_pkg::REQ_GET_CONFIG, 16'h0000, 16'h0000);
    check(answerOut.kind === hub_ep_pkg::ANS_DATA && answerOut.data === 8'h01, "get configuration");
    $display("test control done");
  endtask
  // Hub flag 1 and a port 3 flag must land on bits 0 and 3.
  // Configured but nothing captured yet, so the first poll is refused.
  task automatic t_frame();
    poll(hub_ep_pkg::ANS_NAK, 8'h00);
    @(posedge clk_sys);
    portChange <= 20'h02000;
    hubChange <= 2'h2;
    i_hub_host_model.send_token(hub_ep_pkg::TOK_SOF, 4'h0);
    wait_for(1'b1, 1'b1, 20000);
    @(posedge clk_sys);
    #1;
    check(bitmap === 8'h09, "sampled bitmap");
    poll(hub_ep_pkg::ANS_DATA, 8'h09);
    poll(hub_ep_pkg::ANS_DATA, 8'h09);
    $display("test frame done");
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    #1;
    t_unconf();
    t_suspend();
    t_control();
    t_frame();
    close_out();
  end
  // One shortened frame takes about 17,000 cycles, so 40,000 cycles means the run has hung.
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
endmodule
`default_nettype wire
